//--- design/dbs_consts.vh
// Constants for the DDR2 bank-state command scheduler.
// Assumes a 250 MHz command clock and a four-bank DDR2 part.
`ifndef DBS_CONSTS_VH
`define DBS_CONSTS_VH

////////////////////////////////////////////////////////////////////////////
// Clock rate and ns to cycles, rounding up for least times
`define DBS_CLK_MHZ         250
`define DBS_NS2CK(ns)       ((((ns) * `DBS_CLK_MHZ) + 999) / 1000)

// Part timings in ns (plain defaults, adjust per speed grade)
`define DBS_T_RCD_NS        15
`define DBS_T_RP_NS         15
`define DBS_T_RFC_NS        105
`define DBS_T_WTR_NS        8
`define DBS_T_WR_NS         15
// Mode register access time, in clocks
`define DBS_T_MRD_CK        2
// Least write-to-read turnaround, in clocks
`define DBS_WTR_MIN_CK      2

// A tracker count at or below this lets the next command out, since
// the pins register one edge after the decision.
`define DBS_DONE_CNT        8'h02

////////////////////////////////////////////////////////////////////////////
// Request command codes on i_req_cmd
`define DBS_CMD_ACT         3'h0
`define DBS_CMD_RD          3'h1
`define DBS_CMD_WR          3'h2
`define DBS_CMD_PRE         3'h3
`define DBS_CMD_PREA        3'h4
`define DBS_CMD_REF         3'h5
`define DBS_CMD_LM          3'h6

// Row, column, write strobe levels {ras_n, cas_n, we_n}
`define DBS_PIN_ACT         3'h3
`define DBS_PIN_RD          3'h5
`define DBS_PIN_WR          3'h4
`define DBS_PIN_PRE         3'h2
`define DBS_PIN_REF         3'h1
`define DBS_PIN_LM          3'h0
`define DBS_PIN_NOP         3'h7

// Auto precharge / all banks address bit
`define DBS_AP_BIT          10

`endif

//--- design/dbs_bank.v
// One bank's state tracker for the command scheduler.
// Strobes arrive on the edge the device registers the command.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_consts.vh"

module dbs_bank #(
    parameter [7:0] T_RCD = 8'h04,
    parameter [7:0] T_RP  = 8'h04,
    parameter [7:0] T_RAP = 8'h04,
    parameter [7:0] T_WAP = 8'h0c
) (
    input  wire       i_ref_clk,
    input  wire       i_nrst,
    input  wire       i_act,
    input  wire       i_rd,
    input  wire       i_wr,
    input  wire       i_pre,
    input  wire       i_ap,
    output wire       o_idle,
    output wire       o_open,
    output wire       o_busy
);

    localparam S_IDLE = 3'h0;
    localparam S_ACTV = 3'h1;
    localparam S_OPEN = 3'h2;
    localparam S_PRE  = 3'h3;
    localparam S_RAP  = 3'h4;
    localparam S_WAP  = 3'h5;

    reg  [2:0] state;
    reg  [7:0] cnt;
    wire       done = (cnt <= `DBS_DONE_CNT);

    assign o_idle = (state == S_IDLE) || ((state == S_PRE) && done);
    assign o_open = (state == S_OPEN) || ((state == S_ACTV) && done);
    assign o_busy = !o_idle && !o_open;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            state <= S_IDLE;
            cnt   <= 8'h00;
        end else if (i_act) begin
            state <= S_ACTV;
            cnt   <= T_RCD;
        end else if (i_pre) begin
            state <= S_PRE;
            cnt   <= T_RP;
        end else if (i_rd && i_ap) begin
            state <= S_RAP;
            cnt   <= T_RAP;
        end else if (i_wr && i_ap) begin
            state <= S_WAP;
            cnt   <= T_WAP;
        end else begin
            case (state)
                S_ACTV: begin
                    if (done) begin
                        state <= S_OPEN;
                        cnt   <= 8'h00;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                S_PRE: begin
                    if (done) begin
                        state <= S_IDLE;
                        cnt   <= 8'h00;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                S_RAP, S_WAP: begin
                    // access period over, internal precharge
                    // Done fires one edge early, so tRP gets one extra
                    if (done) begin
                        state <= S_PRE;
                        cnt   <= T_RP + 8'h01;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: begin
                    cnt <= 8'h00;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- design/dbs_sched.v
// DDR2 command scheduler: takes one request at a time, holds it until
// it is legal for the tracked bank and device state, then drives it; a request that the tracked state forbids outright is rejected.
// Assumes requests come from logic on i_ref_clk; the part is already
// initialised; power-down and self refresh are not used.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_consts.vh"

// Summary of operation
// - Never command a bank in transition; others may proceed.
// - Refresh, mode access, precharge all: only deselect until done.
// - Refresh and load mode only with all banks idle, no burst.
// - Unlisted state and command pairs are never issued.
// - Precharge all only when every bank may be precharged.
// - Write after a read only once the read burst completed.
// - Other banks take commands their own state allows.
// - Concurrent auto precharge; no read and write data contention.
// - Write to read turnaround is max of two and tWTR clocks.
// - After write AP: read CL-1+BL/2+tWTR, write BL/2, else 1.
// - After read AP: read BL/2, write BL/2+2, else 1.
module dbs_sched #(
    parameter CL     = 5,
    parameter BL     = 8,
    parameter ADDR_W = 13
) (
    input  wire              i_ref_clk,
    input  wire              i_nrst,
    input  wire              i_req_valid,
    input  wire [2:0]        i_req_cmd,
    input  wire [1:0]        i_req_bank,
    input  wire              i_req_ap,
    input  wire [ADDR_W-1:0] i_req_addr,
    output reg               o_req_done,
    output reg               o_req_reject,
    output reg               o_cke,
    output reg               o_cs_n,
    output reg               o_ras_n,
    output reg               o_cas_n,
    output reg               o_we_n,
    output reg  [1:0]        o_ba,
    output reg  [ADDR_W-1:0] o_addr
);

    ////////////////////////////////////////////////////////////////////////
    // Cycle counts
    localparam integer RCD_I = `DBS_NS2CK(`DBS_T_RCD_NS);
    localparam integer RP_I  = `DBS_NS2CK(`DBS_T_RP_NS);
    localparam integer RFC_I = `DBS_NS2CK(`DBS_T_RFC_NS);
    localparam integer WR_I  = `DBS_NS2CK(`DBS_T_WR_NS);
    localparam integer WTC_I = `DBS_NS2CK(`DBS_T_WTR_NS);
    localparam integer WTR_I = (WTC_I > `DBS_WTR_MIN_CK) ?
                               WTC_I : `DBS_WTR_MIN_CK;
    localparam integer MRD_I = `DBS_T_MRD_CK;
    localparam integer HB_I  = BL / 2;
    localparam integer W2R_I = (CL - 1) + HB_I + WTR_I;
    localparam integer R2W_I = HB_I + 2;
    // write recovery ends the access period
    localparam integer WAP_I = (CL - 1) + HB_I + WR_I;

    localparam [7:0] T_RCD = RCD_I[7:0];
    localparam [7:0] T_RP  = RP_I[7:0];
    localparam [7:0] T_RFC = RFC_I[7:0];
    localparam [7:0] T_MRD = MRD_I[7:0];
    localparam [7:0] T_HB  = HB_I[7:0];
    localparam [7:0] T_W2R = W2R_I[7:0];
    localparam [7:0] T_R2W = R2W_I[7:0];
    localparam [7:0] T_WAP = WAP_I[7:0];

    ////////////////////////////////////////////////////////////////////////
    function [2:0] pin_code;
        input [2:0] cmd;
        begin
            case (cmd)
                `DBS_CMD_ACT:  pin_code = `DBS_PIN_ACT;
                `DBS_CMD_RD:   pin_code = `DBS_PIN_RD;
                `DBS_CMD_WR:   pin_code = `DBS_PIN_WR;
                `DBS_CMD_PRE:  pin_code = `DBS_PIN_PRE;
                `DBS_CMD_PREA: pin_code = `DBS_PIN_PRE;
                `DBS_CMD_REF:  pin_code = `DBS_PIN_REF;
                `DBS_CMD_LM:   pin_code = `DBS_PIN_LM;
                default:       pin_code = `DBS_PIN_NOP;
            endcase
        end
    endfunction

    function [7:0] max8;
        input [7:0] a;
        input [7:0] b;
        begin
            max8 = (a > b) ? a : b;
        end
    endfunction

    function [7:0] dec8;
        input [7:0] a;
        begin
            dec8 = (a != 8'h00) ? (a - 8'h01) : 8'h00;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command as registered by the device this edge
    reg  [2:0] iss_cmd;
    reg  [1:0] iss_bank;
    reg        iss_ap;
    wire       iss_rd = o_req_done && (iss_cmd == `DBS_CMD_RD);
    wire       iss_wr = o_req_done && (iss_cmd == `DBS_CMD_WR);

    wire [3:0] b_idle;
    wire [3:0] b_open;
    wire [3:0] b_busy;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : bank
            wire sel = (iss_bank == g);
            dbs_bank #(
                .T_RCD (T_RCD),
                .T_RP  (T_RP),
                .T_RAP (T_HB),
                .T_WAP (T_WAP)
            ) u_bank (
                .i_ref_clk (i_ref_clk),
                .i_nrst    (i_nrst),
                .i_act     (o_req_done && sel &&
                            (iss_cmd == `DBS_CMD_ACT)),
                .i_rd      (iss_rd && sel),
                .i_wr      (iss_wr && sel),
                .i_pre     (o_req_done &&
                            ((iss_cmd == `DBS_CMD_PREA) ||
                             (sel && (iss_cmd == `DBS_CMD_PRE)))),
                .i_ap      (iss_ap),
                .o_idle    (b_idle[g]),
                .o_open    (b_open[g]),
                .o_busy    (b_busy[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Shared device state and cross-bank spacing
    reg  [7:0] glob_cnt;
    reg  [7:0] wait_rd;
    reg  [7:0] wait_wr;

    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            glob_cnt <= 8'h00;
            wait_rd  <= 8'h00;
            wait_wr  <= 8'h00;
        end else begin
            if (o_req_done && (iss_cmd == `DBS_CMD_REF)) begin
                glob_cnt <= T_RFC;
            end else if (o_req_done && (iss_cmd == `DBS_CMD_LM)) begin
                glob_cnt <= T_MRD;
            end else if (o_req_done && (iss_cmd == `DBS_CMD_PREA)) begin
                glob_cnt <= T_RP;
            end else begin
                glob_cnt <= dec8(glob_cnt);
            end
            // burst spacing on the shared data bus
            if (iss_rd) begin
                wait_rd <= max8(dec8(wait_rd), T_HB);
                wait_wr <= max8(dec8(wait_wr), T_R2W);
            end else if (iss_wr) begin
                wait_rd <= max8(dec8(wait_rd), T_W2R);
                wait_wr <= max8(dec8(wait_wr), T_HB);
            end else begin
                wait_rd <= dec8(wait_rd);
                wait_wr <= dec8(wait_wr);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Legality of the pending request
    wire bi     = b_idle[i_req_bank];
    wire bo     = b_open[i_req_bank];
    wire rd_ok  = (wait_rd <= `DBS_DONE_CNT);
    wire wr_ok  = (wait_wr <= `DBS_DONE_CNT);
    wire g_busy = (glob_cnt > `DBS_DONE_CNT);
    reg  ok;
    reg  bad;

    always @* begin
        ok  = 1'b0;
        bad = 1'b0;
        case (i_req_cmd)
            // a busy bank just waits; others unaffected
            `DBS_CMD_ACT: begin
                ok  = bi;
                bad = bo;
            end
            `DBS_CMD_RD: begin
                ok  = bo && rd_ok;
                bad = bi;
            end
            // write waits out read burst and turnaround
            `DBS_CMD_WR: begin
                ok  = bo && wr_ok;
                bad = bi;
            end
            `DBS_CMD_PRE: begin
                ok  = bi || bo;
            end
            // every bank must be able to precharge
            `DBS_CMD_PREA: begin
                ok  = &(b_idle | b_open);
            end
            `DBS_CMD_REF, `DBS_CMD_LM: begin
                ok  = (&b_idle) && rd_ok && wr_ok;
                bad = |b_open;
            end
            default: begin
                bad = 1'b1;
            end
        endcase
    end

    // One free cycle after each answer, so a held request is not reissued
    wire free = i_req_valid && !o_req_done && !o_req_reject;
    wire go   = free && ok && !g_busy;

    ////////////////////////////////////////////////////////////////////////
    // Pin and answer registers
    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_req_done   <= 1'b0;
            o_req_reject <= 1'b0;
            o_cke        <= 1'b0;
            o_cs_n       <= 1'b1;
            o_ras_n      <= 1'b1;
            o_cas_n      <= 1'b1;
            o_we_n       <= 1'b1;
            o_ba         <= 2'h0;
            o_addr       <= {ADDR_W{1'b0}};
            iss_cmd      <= `DBS_CMD_ACT;
            iss_bank     <= 2'h0;
            iss_ap       <= 1'b0;
        end else begin
            // commands are sampled with CKE held high
            o_cke        <= 1'b1;
            o_req_done   <= go;
            o_req_reject <= free && bad && !go;
            iss_cmd      <= i_req_cmd;
            iss_bank     <= i_req_bank;
            iss_ap       <= i_req_ap;
            if (go) begin
                o_cs_n <= 1'b0;
                {o_ras_n, o_cas_n, o_we_n} <= pin_code(i_req_cmd);
                o_ba   <= i_req_bank;
                o_addr <= i_req_addr;
                if ((i_req_cmd == `DBS_CMD_RD) ||
                    (i_req_cmd == `DBS_CMD_WR)) begin
                    o_addr[`DBS_AP_BIT] <= i_req_ap;
                end else if (i_req_cmd == `DBS_CMD_PRE) begin
                    o_addr[`DBS_AP_BIT] <= 1'b0;
                end else if (i_req_cmd == `DBS_CMD_PREA) begin
                    o_addr[`DBS_AP_BIT] <= 1'b1;
                end
            end else begin
                // deselect between commands; device work carries on
                o_cs_n <= 1'b1;
                {o_ras_n, o_cas_n, o_we_n} <= `DBS_PIN_NOP;
            end
        end
    end

endmodule
`default_nettype wire

//--- verif/dbs_sched_monitor.sv
// Pin-level checker for the DDR2 command scheduler.
// Assumes it is bound to dbs_sched and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_consts.vh"

module dbs_sched_monitor #(
    parameter CL     = 5,
    parameter BL     = 8,
    parameter ADDR_W = 13
) (
    input wire logic              i_ref_clk,
    input wire logic              i_nrst,
    input wire logic              i_req_valid,
    input wire logic              o_req_done,
    input wire logic              o_req_reject,
    input wire logic              o_cke,
    input wire logic              o_cs_n,
    input wire logic              o_ras_n,
    input wire logic              o_cas_n,
    input wire logic              o_we_n,
    input wire logic [1:0]        o_ba,
    input wire logic [ADDR_W-1:0] o_addr
);
    localparam [7:0] RCD = `DBS_NS2CK(`DBS_T_RCD_NS);
    localparam [7:0] RP  = `DBS_NS2CK(`DBS_T_RP_NS);
    localparam [7:0] RFC = `DBS_NS2CK(`DBS_T_RFC_NS);
    localparam [7:0] R2W = BL / 2 + 2;
    localparam [7:0] W2R = CL - 1 + BL / 2 + `DBS_WTR_MIN_CK;

    wire       cmd_on = !o_cs_n && o_cke;
    wire [2:0] pins   = {o_ras_n, o_cas_n, o_we_n};
    reg  [7:0] gap;
    reg  [2:0] prev;
    reg  [1:0] prev_ba;
    reg        prev_all;

    ////////////////////////////////////////////////////////////////////////
    // Cycles since the last command, saturating so idle time never wraps
    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            gap      <= 8'hff;
            prev     <= `DBS_PIN_NOP;
            prev_ba  <= 2'h0;
            prev_all <= 1'b0;
        end else if (cmd_on) begin
            gap      <= 8'h01;
            prev     <= pins;
            prev_ba  <= o_ba;
            prev_all <= o_addr[`DBS_AP_BIT];
        end else if (gap != 8'hff) begin
            gap      <= gap + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    chk_cke_after_reset: assert property (
        $past(i_nrst) |-> o_cke) else $error("cke low after reset");
    chk_cmd_spacing: assert property (
        cmd_on |-> gap >= 8'h02) else $error("commands back to back");
    chk_done_pins: assert property (
        $fell(o_cs_n) |-> o_req_done) else $error("command without done");
    chk_reject_quiet: assert property (
        o_req_reject |-> o_cs_n && !o_req_done) else $error("reject drove pins");
    chk_done_requested: assert property (
        o_req_done |-> $past(i_req_valid)) else $error("command not requested");
    chk_rcd_wait: assert property (
        cmd_on && (pins == `DBS_PIN_RD || pins == `DBS_PIN_WR)
        && prev == `DBS_PIN_ACT && o_ba == prev_ba |-> gap >= RCD)
        else $error("access before row ready");
    chk_rp_wait: assert property (
        cmd_on && pins == `DBS_PIN_ACT && prev == `DBS_PIN_PRE
        && o_ba == prev_ba |-> gap >= RP) else $error("activate in precharge");
    chk_prea_hold: assert property (
        cmd_on && prev == `DBS_PIN_PRE && prev_all |-> gap >= RP)
        else $error("command during precharge all");
    chk_ref_hold: assert property (
        cmd_on && prev == `DBS_PIN_REF |-> gap >= RFC)
        else $error("command during refresh");
    chk_mrd_hold: assert property (
        cmd_on && prev == `DBS_PIN_LM |-> gap >= `DBS_T_MRD_CK)
        else $error("command during mode access");
    chk_read_to_write: assert property (
        cmd_on && pins == `DBS_PIN_WR && prev == `DBS_PIN_RD |-> gap >= R2W)
        else $error("write too soon after read");
    chk_write_to_read: assert property (
        cmd_on && pins == `DBS_PIN_RD && prev == `DBS_PIN_WR |-> gap >= W2R)
        else $error("read too soon after write");

    cover property (cmd_on && prev == `DBS_PIN_REF);
    cover property (o_req_reject);
    cover property (cmd_on && pins == `DBS_PIN_WR && prev == `DBS_PIN_RD);
endmodule

bind dbs_sched dbs_sched_monitor #(.CL(CL), .BL(BL), .ADDR_W(ADDR_W))
    i_dbs_sched_monitor (.i_ref_clk, .i_nrst, .i_req_valid, .o_req_done,
    .o_req_reject, .o_cke, .o_cs_n, .o_ras_n, .o_cas_n, .o_we_n, .o_ba,
    .o_addr);
`default_nettype wire

//--- verif/dbs_dev_model.sv
// Behavioural four-bank DDR2 part: tracks bank state, counts misuse.
// Assumes the part is initialised; data pins are not modelled.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_consts.vh"

module dbs_dev_model #(
    parameter CL = 5,
    parameter BL = 8
) (
    input wire logic        i_ref_clk,
    input wire logic        i_nrst,
    input wire logic        i_cke,
    input wire logic        i_cs_n,
    input wire logic        i_ras_n,
    input wire logic        i_cas_n,
    input wire logic        i_we_n,
    input wire logic [1:0]  i_ba,
    input wire logic [12:0] i_addr,
    output var logic [7:0]  o_err_cnt,
    output var logic [3:0]  o_open
);
    localparam [7:0] RCD = `DBS_NS2CK(`DBS_T_RCD_NS);
    localparam [7:0] RP  = `DBS_NS2CK(`DBS_T_RP_NS);
    localparam [7:0] RFC = `DBS_NS2CK(`DBS_T_RFC_NS);
    localparam [7:0] RAP = BL / 2 + RP;
    localparam [7:0] WAP = CL - 1 + BL / 2 + `DBS_NS2CK(`DBS_T_WR_NS) + RP;

    wire [2:0] cmd = {i_ras_n, i_cas_n, i_we_n};
    wire       any_busy;
    reg  [7:0] busy [0:3];
    reg  [7:0] dev_busy;
    reg        bad;
    integer    k;

    assign any_busy = |{busy[0], busy[1], busy[2], busy[3]};

    // own timers per bank and for the part
    // decode only selected edges with clock enable high
    always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_err_cnt <= 8'h00;
            o_open    <= 4'h0;
            dev_busy  <= 8'h00;
            for (k = 0; k < 4; k = k + 1) busy[k] <= 8'h00;
        end else begin
            for (k = 0; k < 4; k = k + 1)
                if (busy[k] != 8'h00) busy[k] <= busy[k] - 8'h01;
            if (dev_busy != 8'h00) dev_busy <= dev_busy - 8'h01;
            bad = 1'b0;
            if (i_cke && !i_cs_n && cmd != 3'h7) begin
                bad = dev_busy != 8'h00;
                case (cmd)
                    3'h3: begin
                        bad = bad | o_open[i_ba] | (busy[i_ba] != 8'h00);
                        o_open[i_ba] <= 1'b1;
                        busy[i_ba]   <= RCD - 8'h01;
                    end
                    3'h5, 3'h4: begin
                        bad = bad | !o_open[i_ba] | (busy[i_ba] != 8'h00);
                        if (i_addr[`DBS_AP_BIT]) begin
                            o_open[i_ba] <= 1'b0;
                            busy[i_ba]   <= (cmd == 3'h5 ? RAP : WAP) - 8'h01;
                        end
                    end
                    // single or all bank precharge lasts tRP
                    3'h2: begin
                        if (i_addr[`DBS_AP_BIT]) begin
                            bad      = bad | any_busy;
                            o_open   <= 4'h0;
                            dev_busy <= RP - 8'h01;
                        end else begin
                            bad          = bad | (busy[i_ba] != 8'h00);
                            o_open[i_ba] <= 1'b0;
                            busy[i_ba]   <= RP - 8'h01;
                        end
                    end
                    // refresh holds the part for tRFC
                    3'h1: begin
                        bad      = bad | (o_open != 4'h0) | any_busy;
                        dev_busy <= RFC - 8'h01;
                    end
                    // mode access holds the part for tMRD
                    default: begin
                        bad      = bad | (o_open != 4'h0) | any_busy;
                        dev_busy <= `DBS_T_MRD_CK - 1;
                    end
                endcase
            end
            o_err_cnt <= o_err_cnt + {7'h00, bad};
        end
    end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for dbs_sched against the behavioural part.
// Assumes a 250 MHz clock and the default timing header.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_consts.vh"

module tb_top;
    localparam       CL  = 5;
    localparam       BL  = 8;
    localparam [7:0] RCD = `DBS_NS2CK(`DBS_T_RCD_NS);
    localparam [7:0] RP  = `DBS_NS2CK(`DBS_T_RP_NS);
    localparam [7:0] RFC = `DBS_NS2CK(`DBS_T_RFC_NS);
    localparam [7:0] TWR = `DBS_NS2CK(`DBS_T_WR_NS);

    reg         i_ref_clk   = 1'b0;
    reg         i_nrst      = 1'b0;
    reg         i_req_valid = 1'b0;
    reg  [2:0]  i_req_cmd   = 3'h0;
    reg  [1:0]  i_req_bank  = 2'h0;
    reg         i_req_ap    = 1'b0;
    reg  [12:0] i_req_addr  = 13'h0000;
    wire        o_req_done, o_req_reject, o_cke, o_cs_n;
    wire        o_ras_n, o_cas_n, o_we_n;
    wire [1:0]  o_ba;
    wire [12:0] o_addr;
    wire [7:0]  err_cnt;
    wire [3:0]  open_banks;
    integer     fails = 0, n_tests = 0, cyc = 0, t_prev = 0, t_last = 0;

    dbs_sched #(.CL(CL), .BL(BL), .ADDR_W(13)) i_dbs_sched (.i_ref_clk,
        .i_nrst, .i_req_valid, .i_req_cmd, .i_req_bank, .i_req_ap,
        .i_req_addr, .o_req_done, .o_req_reject, .o_cke, .o_cs_n, .o_ras_n,
        .o_cas_n, .o_we_n, .o_ba, .o_addr);
    dbs_dev_model #(.CL(CL), .BL(BL)) i_dbs_dev_model (.i_ref_clk,
        .i_nrst, .i_cke(o_cke), .i_cs_n(o_cs_n), .i_ras_n(o_ras_n),
        .i_cas_n(o_cas_n), .i_we_n(o_we_n), .i_ba(o_ba), .i_addr(o_addr),
        .o_err_cnt(err_cnt), .o_open(open_banks));

    initial forever #2 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        begin
            if (fails == 0 && n_tests > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    task check(input [15:0] got, input [15:0] exp, input [79:0] what);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    function [2:0] pin_of(input [2:0] c);
        case (c)
            3'h0: pin_of = 3'h3;
            3'h1: pin_of = 3'h5;
            3'h2: pin_of = 3'h4;
            3'h3, 3'h4: pin_of = 3'h2;
            3'h5: pin_of = 3'h1;
            default: pin_of = 3'h0;
        endcase
    endfunction

    // Holds the request until answered, then checks the pins
    task req(input [2:0] c, input [1:0] b, input ap, input ok);
        integer n;
        begin
            @(negedge i_ref_clk);
            i_req_valid = 1'b1;
            i_req_cmd   = c;
            i_req_bank  = b;
            i_req_ap    = ap;
            i_req_addr  = {5'h00, c, b, 3'h5};
            n = 0;
            @(negedge i_ref_clk);
            while (o_req_done !== 1'b1 && o_req_reject !== 1'b1) begin
                n = n + 1;
                if (n > 200) begin
                    fails = fails + 1;
                    complete_run;
                end
                @(negedge i_ref_clk);
            end
            check({14'h0000, o_req_done, o_req_reject},
                  {14'h0000, ok, !ok}, "answer");
            if (o_req_done === 1'b1) begin
                check({12'h000, o_cs_n, o_ras_n, o_cas_n, o_we_n},
                      {13'h0000, pin_of(c)}, "pins");
                if (c <= 3'h2)
                    check({1'b0, o_ba, o_addr},
                          {1'b0, b, 2'h0, ap, 2'h0, c, b, 3'h5}, "ba_addr");
                t_prev = t_last;
                t_last = cyc;
            end else begin
                check({15'h0000, o_cs_n}, 16'h0001, "cs_n");
            end
            i_req_valid = 1'b0;
        end
    endtask

    task gap(input [15:0] exp);
        check(t_last[15:0] - t_prev[15:0], exp, "gap");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task sc_reset;
        check({14'h0000, o_cke, o_cs_n}, 16'h0003, "cke_cs");
    endtask

    task sc_row;
        begin
            req(3'h0, 2'h0, 1'b0, 1'b1);
            req(3'h1, 2'h0, 1'b0, 1'b1);
            gap(RCD);
            req(3'h2, 2'h0, 1'b0, 1'b1);
            gap(BL / 2 + 2);
            req(3'h1, 2'h0, 1'b1, 1'b1);
            gap(CL - 1 + BL / 2 + `DBS_WTR_MIN_CK);
            req(3'h0, 2'h0, 1'b0, 1'b1);
            gap(BL / 2 + RP);
        end
    endtask

    task sc_auto_pre;
        begin
            req(3'h0, 2'h1, 1'b0, 1'b1);
            req(3'h2, 2'h1, 1'b1, 1'b1);
            req(3'h0, 2'h2, 1'b0, 1'b1);
            gap(16'h0002);
            req(3'h0, 2'h1, 1'b0, 1'b1);
            gap(CL - 1 + BL / 2 + TWR + RP - 2);
            req(3'h3, 2'h2, 1'b0, 1'b1);
            req(3'h0, 2'h2, 1'b0, 1'b1);
            gap(RP);
        end
    endtask

    task sc_refuse;
        begin
            req(3'h5, 2'h0, 1'b0, 1'b0);
            req(3'h1, 2'h3, 1'b0, 1'b0);
            req(3'h0, 2'h0, 1'b0, 1'b0);
            req(3'h7, 2'h0, 1'b0, 1'b0);
        end
    endtask

    task sc_device;
        begin
            req(3'h4, 2'h0, 1'b0, 1'b1);
            req(3'h5, 2'h0, 1'b0, 1'b1);
            gap(RP);
            req(3'h6, 2'h1, 1'b0, 1'b1);
            gap(RFC);
            req(3'h0, 2'h3, 1'b0, 1'b1);
            gap(`DBS_T_MRD_CK);
            req(3'h1, 2'h1, 1'b0, 1'b0);
            check({12'h000, open_banks}, 16'h0008, "open");
            check({8'h00, err_cnt}, 16'h0000, "misuse");
        end
    endtask

    initial begin
        repeat (12) @(negedge i_ref_clk);
        i_nrst = 1'b1;
        @(negedge i_ref_clk);
        @(negedge i_ref_clk);
        sc_reset;
        sc_row;
        sc_auto_pre;
        sc_refuse;
        sc_device;
        complete_run;
    end
endmodule
`default_nettype wire
